/* shared/sbcsd_cfg.svh */
// Purpose: constants for the serial command frame decoder
// Assumes: 16-bit frames, msb first
// Notes:   field positions and opcode values
`ifndef SBCSD_CFG_SVH
`define SBCSD_CFG_SVH
`define SBCSD_FRAME_BITS   16
`define SBCSD_CNT_W        5
`define SBCSD_OP_HI        15
`define SBCSD_OP_LO        14
`define SBCSD_ADDR_HI      13
`define SBCSD_ADDR_LO      9
`define SBCSD_PN_BIT       8
`define SBCSD_DATA_HI      7
`define SBCSD_INFO_BIT     7
`define SBCSD_OP_READ      2'h0
`define SBCSD_OP_WRITE     2'h1
`define SBCSD_OP_RSVD      2'h2
`define SBCSD_OP_FLAG      2'h3
`define SBCSD_NREGS        32
`define SBCSD_REG_RESET    8'h00
`define SBCSD_CLK_DIV      4
`endif

/* shared/sbcsd_pkg.sv */
// Purpose: shared types for the serial command frame decoder
// Assumes: included constants header
// Notes:   none
package sbcsd_pkg;
  typedef logic [1:0]  sbcsd_op_t;
  typedef logic [4:0]  sbcsd_addr_t;
  typedef logic [15:0] sbcsd_word_t;
  typedef enum logic [1:0] {
    SBCSD_M_IDLE = 2'h0,
    SBCSD_M_SHIFT = 2'h1,
    SBCSD_M_DONE = 2'h3
  } sbcsd_mst_e;
endpackage

/* shared/sbcsd_if.sv */
// Purpose: serial link between command master and device
// Assumes: master drives clock, select and mosi
// Notes:   miso driven by device while selected
`timescale 1ns/1ps
interface sbcsd_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport mst (output sclk, output cs_n, output mosi, input miso);
endinterface

/* src/sbcsd_device.sv */
// Contract
// R1: frames are exactly sixteen bits each way
// R2: bits 15-14 carry the operation code
// R3: bits 13-9 carry register address
// R4: low byte carries data to store
// R5: opcode 00 read, 01 write, 11 flags
// R6: write stores data into addressed register
// R7: flag read returns flags in low byte
// R8: master sets bit 8 on reads
// R9: write bit8 zero: no parity or parity 0
// R10: write bit8 one: parity enabled, parity one
// R11: upper reply byte is fixed status
// R12: write reply is status plus extended status
// R13: read reply is status plus register content
// R14: every register reads back last written value
// R15: some registers also hold device flags
// R16: read bit 7 selects control or info
// R17: act only on complete sixteen-bit frames
// Purpose: device end, decodes frames on the link clock
// Assumes: mode 0 style, mosi sampled on rising sclk, miso changes on rising
// Notes:   user side on ref_clk; commit crosses by toggle
`timescale 1ns/1ps
`include "sbcsd_cfg.svh"
module sbcsd_device #(
  parameter int NREGS = `SBCSD_NREGS
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  sbcsd_if.dev             link,
  input  wire logic [7:0]  fixed_status,
  input  wire logic [7:0]  ext_status,
  input  wire logic [7:0]  dev_info,
  input  wire logic [NREGS*8-1:0] flags_in,
  output logic [NREGS*8-1:0] ctrl_regs,
  output logic             wr_strobe,
  output logic [4:0]       wr_addr,
  output logic             parity_bit,
  output logic             parity_err
);
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic [15:0] cmd_q;
  logic        tog_q;
  logic [7:0]  regs_q [NREGS];
  logic [15:0] reply_q;
  logic [7:0]  low_d;
  logic [NREGS*8-1:0] ctrl_flat;
  logic [2:0]  tog_s_q;
  logic [1:0]  op_early;
  logic [4:0]  addr_early;
  logic [NREGS*8-1:0] ctrl_q;
  logic        wr_q;
  logic [4:0]  wa_q;
  logic        pb_q;
  logic        pe_q;
  logic        miso_q;

  // shift in msb first; counter reset by deselect drops partial frames
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_q <= '0; // R17
    end else begin
      sh_q <= {sh_q[14:0], link.mosi};
      if (cnt_q == 5'(`SBCSD_FRAME_BITS - 1)) begin
        cnt_q <= '0; // R1
        cmd_q <= {sh_q[14:0], link.mosi};
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // commit toggle must survive deselect, so only the user reset clears it
  always_ff @(posedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      tog_q <= 1'b0;
    end else if (!link.cs_n && (cnt_q == 5'(`SBCSD_FRAME_BITS - 1))) begin
      tog_q <= ~tog_q; // R17
    end
  end

  // at the ninth rise sh_q holds bits 15..8 and mosi carries data bit 7
  assign op_early   = sh_q[`SBCSD_OP_HI-`SBCSD_PN_BIT -: 2];
  assign addr_early = sh_q[`SBCSD_ADDR_HI-`SBCSD_PN_BIT -: 5];

  // register file read across domains: contents are quasi-static during a frame
  always_comb begin
    low_d = ext_status;
    case (op_early)
      `SBCSD_OP_READ: low_d = link.mosi ? dev_info : regs_q[addr_early]; // R13 R14 R16
      `SBCSD_OP_FLAG: low_d = flags_in[{addr_early, 3'h0} +: 8]; // R7 R15
      default:        low_d = ext_status; // R12
    endcase
  end

  // miso moves on rising sclk and is taken by the master on falling sclk
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      reply_q <= '0;
      miso_q  <= 1'b0;
    end else if (cnt_q == 5'h00) begin
      reply_q <= {fixed_status[6:0], 9'h000}; // R11
      miso_q  <= fixed_status[7];
    end else if (cnt_q == 5'(`SBCSD_FRAME_BITS - `SBCSD_PN_BIT)) begin
      reply_q <= {low_d[6:0], 9'h000};
      miso_q  <= low_d[7];
    end else begin
      reply_q <= {reply_q[14:0], 1'b0};
      miso_q  <= reply_q[15];
    end
  end
  assign link.miso = miso_q;

  // user-domain commit: toggle synchroniser, command word stable by then
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tog_s_q <= '0;
    end else begin
      tog_s_q <= {tog_s_q[1:0], tog_q};
    end
  end

  // register file, written on opcode 01 only; 10 is ignored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NREGS; i++) regs_q[i] <= `SBCSD_REG_RESET;
      wr_q <= 1'b0;
      wa_q <= '0;
      pb_q <= 1'b0;
      pe_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if ((tog_s_q[1] != tog_s_q[2]) &&
          (cmd_q[`SBCSD_OP_HI:`SBCSD_OP_LO] == `SBCSD_OP_WRITE)) begin // R5 R2
        regs_q[cmd_q[`SBCSD_ADDR_HI:`SBCSD_ADDR_LO]] <= cmd_q[`SBCSD_DATA_HI:0]; // R6 R4 R3
        wr_q <= 1'b1;
        wa_q <= cmd_q[`SBCSD_ADDR_HI:`SBCSD_ADDR_LO];
        pb_q <= cmd_q[`SBCSD_PN_BIT]; // R9 R10
        pe_q <= (^cmd_q[`SBCSD_DATA_HI:0]) != cmd_q[`SBCSD_PN_BIT];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NREGS; i++) ctrl_flat[i*8 +: 8] = regs_q[i];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_flat;
    end
  end

  assign ctrl_regs  = ctrl_q;
  assign wr_strobe  = wr_q;
  assign wr_addr    = wa_q;
  assign parity_bit = pb_q;
  assign parity_err = pe_q;
endmodule

/* src/sbcsd_master.sv */
// Purpose: master end, sends one 16-bit command and returns the reply
// Assumes: sclk derived from ref_clk by a divider
// Notes:   read commands force bit 8 high
`timescale 1ns/1ps
`include "sbcsd_cfg.svh"
module sbcsd_master (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  sbcsd_if.mst             link,
  input  wire logic        start,
  input  wire logic [1:0]  op,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  data,
  input  wire logic        parity_en,
  output logic             busy,
  output logic             done,
  output logic [15:0]      reply
);
  sbcsd_pkg::sbcsd_mst_e st_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [4:0]  bits_q;
  logic [1:0]  div_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        busy_q;
  logic        done_q;
  logic        miso_s1_q;
  logic        miso_s2_q;
  logic        pn;

  // R8 R9 R10
  assign pn = (op == `SBCSD_OP_WRITE) ? (parity_en & ^data) : 1'b1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= sbcsd_pkg::SBCSD_M_IDLE;
      tx_q   <= '0;
      rx_q   <= '0;
      bits_q <= '0;
      div_q  <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        sbcsd_pkg::SBCSD_M_IDLE: begin
          if (start) begin
            tx_q   <= {op, addr, pn, data}; // R2 R3 R4
            bits_q <= '0;
            div_q  <= '0;
            cs_n_q <= 1'b0;
            busy_q <= 1'b1;
            st_q   <= sbcsd_pkg::SBCSD_M_SHIFT;
          end
        end
        sbcsd_pkg::SBCSD_M_SHIFT: begin
          div_q <= div_q + 2'h1;
          if (div_q == 2'(`SBCSD_CLK_DIV - 1)) begin
            if (!sclk_q) begin
              sclk_q <= 1'b1;
            end else begin
              sclk_q <= 1'b0;
              rx_q   <= {rx_q[14:0], miso_s2_q};
              tx_q   <= {tx_q[14:0], 1'b0};
              if (bits_q == 5'(`SBCSD_FRAME_BITS - 1)) begin
                st_q <= sbcsd_pkg::SBCSD_M_DONE; // R1
              end
              bits_q <= bits_q + 5'h01;
            end
          end
        end
        sbcsd_pkg::SBCSD_M_DONE: begin
          cs_n_q <= 1'b1;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q   <= sbcsd_pkg::SBCSD_M_IDLE;
        end
        default: st_q <= sbcsd_pkg::SBCSD_M_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = tx_q[15];
  assign busy      = busy_q;
  assign done      = done_q;
  assign reply     = rx_q;
endmodule

/* sim/sbcsd_monitor.sv */
// Purpose: link checks for command frames
// Assumes: sclk made from ref_clk, msb first
// Notes:   sclk edges seen by sampling on ref_clk
`timescale 1ns/1ps
module sbcsd_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic       sclk_q;
  logic [4:0] cnt_q;
  logic [6:0] hi_q;
  logic       rise;
  assign rise = sclk & ~sclk_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // counts clock rises inside a frame
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cnt_q <= 5'h0;
    else if (cs_n) cnt_q <= 5'h0;
    else if (rise) cnt_q <= cnt_q + 5'h1;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hi_q <= 7'h0;
    else if (rise) hi_q <= {hi_q[5:0], mosi};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_idle_clk_low: assert property (cs_n |-> !sclk) else $error("clock outside frame");
  a_frame_bits: assert property ($rose(cs_n) |-> cnt_q == 5'h10) else $error("bad count");
  a_frame_ends: assert property ($fell(cs_n) |-> ##[100:200] $rose(cs_n))
    else $error("frame too long");
  a_no_extra_clk: assert property (cnt_q == 5'h10 |-> !rise) else $error("extra clock");
  a_clk_in_frame: assert property (rise |-> !cs_n) else $error("clock without select");
  a_read_next_set: assert property (rise && cnt_q == 5'h7 && hi_q[6] == hi_q[5] |-> mosi)
    else $error("read bit 8 low");
  a_mosi_hold: assert property (sclk && sclk_q |-> $stable(mosi)) else $error("mosi moved");
  a_miso_hold: assert property (!sclk && !sclk_q && !cs_n |-> $stable(miso))
    else $error("miso moved");
  c_frame: cover property ($rose(cs_n) && cnt_q == 5'h10);
  c_flag: cover property (rise && cnt_q == 5'h7 && hi_q[6:5] == 2'h3);
  c_write: cover property (rise && cnt_q == 5'h7 && hi_q[6:5] == 2'h1);
endmodule

/* sim/testbench.sv */
// Purpose: both ends joined, command traffic checked
// Assumes: device reply bytes set by the bench
// Notes:   sclk comes from the master divider
`timescale 1ns/1ps
module testbench;
  logic         ref_clk, resetn, start, parity_en, busy, done;
  logic         wr_strobe, parity_bit, parity_err;
  logic [1:0]   op;
  logic [4:0]   addr, wr_addr;
  logic [7:0]   data, fixed_status, ext_status, dev_info;
  logic [15:0]  reply;
  logic [255:0] flags_in, ctrl_regs;
  int           error_cnt, checks_done, wr_cnt;
  sbcsd_if link ();
  sbcsd_master i_sbcsd_master (.ref_clk, .resetn, .link(link.mst), .start, .op, .addr,
    .data, .parity_en, .busy, .done, .reply);
  sbcsd_device i_sbcsd_device (.ref_clk, .resetn, .link(link.dev), .fixed_status,
    .ext_status, .dev_info, .flags_in, .ctrl_regs, .wr_strobe, .wr_addr, .parity_bit,
    .parity_err);
  sbcsd_monitor i_sbcsd_monitor (.ref_clk, .resetn, .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso(link.miso));
  always @(posedge ref_clk) begin
    if (wr_strobe === 1'b1) wr_cnt++;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one whole frame: start pulse, bounded wait for done
  task automatic xfer(input logic [1:0] o, input logic [4:0] a, input logic [7:0] d,
                      input logic p);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    op = o;
    addr = a;
    data = d;
    parity_en = p;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    check("busy high", 16'h0001, {15'h0000, busy});
    while (done !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 400) begin
        error_cnt++;
        finish_test();
      end
    end
    check("busy low", 16'h0000, {15'h0000, busy});
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    op = 2'h0;
    addr = 5'h00;
    data = 8'h00;
    parity_en = 1'b0;
    fixed_status = 8'hC3;
    ext_status = 8'h5A;
    dev_info = 8'h96;
    flags_in = '0;
    flags_in[31:24] = 8'h3C;
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    xfer(2'h0, 5'h05, 8'h00, 1'b0);
    check("reset read", 16'hC300, reply);
    $display("test reset read done");
    xfer(2'h1, 5'h1F, 8'hA7, 1'b1);
    check("write reply", 16'hC35A, reply);
    check("reg 31", 16'h00A7, {8'h00, ctrl_regs[255:248]});
    check("wr_addr", 16'h001F, {11'h000, wr_addr});
    check("parity one", 16'h0001, {15'h0000, parity_bit});
    check("parity err", 16'h0000, {15'h0000, parity_err});
    check("wr pulses", 16'h0001, 16'(wr_cnt));
    $display("test write parity done");
    xfer(2'h1, 5'h00, 8'h6E, 1'b0);
    check("reg 0", 16'h006E, {8'h00, ctrl_regs[7:0]});
    check("parity off", 16'h0000, {15'h0000, parity_bit});
    $display("test write plain done");
    xfer(2'h0, 5'h1F, 8'h00, 1'b0);
    check("read back", 16'hC3A7, reply);
    xfer(2'h0, 5'h1F, 8'h80, 1'b0);
    check("info read", 16'hC396, reply);
    $display("test read back done");
    xfer(2'h3, 5'h03, 8'h00, 1'b0);
    check("flag read", 16'hC33C, reply);
    $display("test flag read done");
    xfer(2'h2, 5'h1F, 8'h11, 1'b1);
    check("reserved keeps", 16'h00A7, {8'h00, ctrl_regs[255:248]});
    check("reserved status", 16'h00C3, {8'h00, reply[15:8]});
    check("wr total", 16'h0002, 16'(wr_cnt));
    $display("test reserved done");
    finish_test();
  end
endmodule
